// File: wgs_consts.vh
// Purpose: constants for the wake / gpio / selective wake status bank
// Assumes: 7-bit register addresses, 8-bit data
// Notes: definitions only
`ifndef WGS_CONSTS_VH
`define WGS_CONSTS_VH
`define WGS_ADDR_WAKE_SRC1 7'h47
`define WGS_ADDR_PIN_LVL 7'h48
`define WGS_ADDR_GPIO_OVERCURRENT_FLAG 7'h54
`define WGS_ADDR_GPIO_OPENLOAD_FLAG 7'h55
`define WGS_ADDR_SWK 7'h70
`define WGS_ADDR_SWK_ECNT 7'h71
`define WGS_BIT_GPIO_WAKE 4
`define WGS_BIT_DEV_LVL 7
`define WGS_BIT_CFG_STRAP 6
`define WGS_BIT_GPIO_PIN_LEVEL 4
`define WGS_BIT_WAKE_LVL 0
`define WGS_BIT_GPIO_OVERCURRENT_FLAG 6
`define WGS_BIT_GPIO_OPENLOAD_FLAG 6
`define WGS_BIT_SYNC 6
`define WGS_BIT_SILENCE 3
`define WGS_BIT_SWK_ACTIVE 2
`define WGS_BIT_PATTERN 1
`define WGS_BIT_FRAME 0
`define WGS_ZERO8 8'h00
`define WGS_GPIO_CFG_FO 2'h0
`define WGS_GPIO_CFG_WK 2'h1
`define WGS_GPIO_CFG_LS 2'h2
`define WGS_GPIO_CFG_HS 2'h3
`define WGS_TRX_SWK_BIT 2
`define WGS_TRX_NO_ACT 3'h4
`define WGS_TRX_RESET 3'h0
`define WGS_ECNT_MSB 5
`define WGS_PIN_COUNT 4
`endif

// File: wgs_sync2.v
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: single clock clk, synchronous reset rst
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module wgs_sync2 #(
	parameter W = 4
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	always @(posedge clk) begin
		if (rst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end
	assign dout = sync_q;
endmodule // wgs_sync2
`default_nettype wire

// File: wgs_sticky.v
// Purpose: sticky status flag, set by event, cleared by software
// Assumes: clr and set are on clk
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module wgs_sticky (
	input wire clk,
	input wire rst,
	input wire set,
	input wire clr,
	output wire flag
);
	reg flag_q;
	always @(posedge clk) begin
		if (rst)
			flag_q <= 1'b0;
		else if (set)
			flag_q <= 1'b1;
		else if (clr)
			flag_q <= 1'b0;
	end
	assign flag = flag_q;
endmodule // wgs_sticky
`default_nettype wire

// File: wgs_status_bank.v
// Purpose: wake, pin level, gpio fault and selective wake status registers
// Assumes: register port with address, read strobe and clear strobe
// Notes: pin levels and strap come from pins and are synchronised
//   status flags are single bits; the error count passes straight through
//   bus timeout has no clear here, its owner register lives elsewhere
//   read data is registered, so it lags the read strobe by one cycle
//
// Overview of operation
// - gpio wake event sets wake source bit 4 until software clears it.
// - reserved bits in every status register read as zero.
// - pin level bit 7 shows test pin: 0 user, 1 development mode.
// - pin level bit 6 shows interrupt pin pull-up strap state.
// - pin level bit 4 shows gpio pin level in wake/low/high switch use.
// - bit 0 shows wake pin level; refreshed in normal, stop, init, restart.
// - in cyclic sense or wake, levels refresh only after each sample.
// - gpio level refreshes only for wake/switch use without cyclic sense.
// - a disabled feature's level bit stops refreshing.
// - high-voltage measurement enabled clears both level bits, no refresh.
// - overcurrent bit 6 sets on gpio switch overcurrent.
// - one overcurrent flag for both switches, held until cleared.
// - open-load bit 6 sets on open load in high-side switch use.
// - sync bit 6 is 1 only after an error-free bus frame.
// - silence bit 3 set when bus silent beyond silence time.
// - active bit 2 needs no system error, config valid, mode bit 2.
// - selective wake activates on mode change, except to code 100.
// - pattern sets bit 1, matching wake frame sets bit 0.
// - timeout flag sets with silence while mode bit 2, stays set.
`timescale 1ns/1ps
`default_nettype none
`include "wgs_consts.vh"
module wgs_status_bank (
	input wire clk,
	input wire rst,
	input wire [6:0] regAddr,
	input wire regRead,
	input wire regClear,
	output reg [7:0] regRdata,
	input wire wakePin,
	input wire gpioPin,
	input wire testPin,
	input wire intStrapPin,
	input wire modeActive,
	input wire cyclicMode,
	input wire sampleStrobe,
	input wire wakeEnable,
	input wire gpioEnable,
	input wire [1:0] gpioConfig,
	input wire gpioCyclicSense,
	input wire hvMeasureEnable,
	input wire gpioWakeEvent,
	input wire gpioOvercurrentEvent,
	input wire gpioOpenloadEvent,
	input wire frameOk,
	input wire busSilent,
	input wire wakePatternEvent,
	input wire wakeFrameEvent,
	input wire swkSystemError,
	input wire configValid,
	input wire [2:0] trxMode,
	input wire trxModeWrite,
	input wire [5:0] errorCount,
	output wire busTimeoutFlag,
	output wire selectiveWakeActive
);
	wire [3:0] pinSync;
	wire wakeSync;
	wire gpioSync;
	wire testSync;
	wire strapSync;
	wire clrWake1;
	wire clrOc;
	wire clrOl;
	wire gpioWakeFlag;
	wire gpioOvercurrentFlag;
	wire gpioOpenloadFlag;
	wire gpioAsSwitch;
	wire gpioLevelUse;
	wire refreshTick;
	wire swkMode;
	wire gpioWakeSet;
	wire gpioOvercurrentSet;
	wire gpioOpenloadSet;
	wire modeChangeArms;

	reg wakePinLevel_q;
	reg wakePinLevel_d;
	reg gpioPinLevel_q;
	reg gpioPinLevel_d;
	reg devModeLevel_q;
	reg strapState_q;

	reg syncSeen_q;
	reg silence_q;
	reg active_q;
	reg active_d;
	reg pattern_q;
	reg frame_q;
	reg timeout_q;
	reg [2:0] trxPrev_q;
	reg [7:0] readWord_d;

	function clear_hit;
		input [6:0] addr;
		input [6:0] target;
		input clr;
		begin
			clear_hit = clr && (addr == target);
		end
	endfunction

	// gpio use decode, shared by flag gating and level refresh
	function gpio_cfg_is;
		input [1:0] cfg;
		input [1:0] code;
		begin
			gpio_cfg_is = (cfg == code);
		end
	endfunction

	// only the synchronised copy feeds logic; raw pins are never read
	wgs_sync2 #(
		.W(`WGS_PIN_COUNT)
	) pinSyncInst (
		.clk(clk),
		.rst(rst),
		.din({intStrapPin, testPin, gpioPin, wakePin}),
		.dout(pinSync)
	);
	assign wakeSync = pinSync[0];
	assign gpioSync = pinSync[1];
	assign testSync = pinSync[2];
	assign strapSync = pinSync[3];

	// a clear aimed at any other address leaves these flags alone
	assign clrWake1 = clear_hit(regAddr, `WGS_ADDR_WAKE_SRC1, regClear);
	assign clrOc = clear_hit(regAddr, `WGS_ADDR_GPIO_OVERCURRENT_FLAG, regClear);
	assign clrOl = clear_hit(regAddr, `WGS_ADDR_GPIO_OPENLOAD_FLAG, regClear);

	// events outside the matching gpio use are dropped, not queued
	assign gpioWakeSet = gpioWakeEvent &&
		gpio_cfg_is(gpioConfig, `WGS_GPIO_CFG_WK);
	assign gpioAsSwitch = gpio_cfg_is(gpioConfig, `WGS_GPIO_CFG_LS) ||
		gpio_cfg_is(gpioConfig, `WGS_GPIO_CFG_HS);
	assign gpioOvercurrentSet = gpioOvercurrentEvent &&
		gpioAsSwitch;
	assign gpioOpenloadSet = gpioOpenloadEvent &&
		gpio_cfg_is(gpioConfig, `WGS_GPIO_CFG_HS);

	wgs_sticky wakeFlagInst (
		.clk(clk),
		.rst(rst),
		.set(gpioWakeSet),
		.clr(clrWake1),
		.flag(gpioWakeFlag)
	);

	// flag persists after reconfiguration; only the clear drops it
	wgs_sticky ocFlagInst (
		.clk(clk),
		.rst(rst),
		.set(gpioOvercurrentSet),
		.clr(clrOc),
		.flag(gpioOvercurrentFlag)
	);

	wgs_sticky olFlagInst (
		.clk(clk),
		.rst(rst),
		.set(gpioOpenloadSet),
		.clr(clrOl),
		.flag(gpioOpenloadFlag)
	);

	// fail output use reports through the failure flag elsewhere
	assign gpioLevelUse = gpioEnable && !gpioCyclicSense &&
		!gpio_cfg_is(gpioConfig, `WGS_GPIO_CFG_FO);
	assign refreshTick = modeActive && (!cyclicMode || sampleStrobe);

	// hv measurement wins over any refresh
	always @* begin
		wakePinLevel_d = wakePinLevel_q;
		gpioPinLevel_d = gpioPinLevel_q;
		if (hvMeasureEnable) begin
			wakePinLevel_d = 1'b0;
			gpioPinLevel_d = 1'b0;
		end else if (refreshTick) begin
			if (wakeEnable)
				wakePinLevel_d = wakeSync;
			if (gpioLevelUse)
				gpioPinLevel_d = gpioSync;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wakePinLevel_q <= 1'b0;
			gpioPinLevel_q <= 1'b0;
		end else begin
			wakePinLevel_q <= wakePinLevel_d;
			gpioPinLevel_q <= gpioPinLevel_d;
		end
	end

	// straps are followed all the time, so a late pull-up change shows up
	always @(posedge clk) begin
		if (rst) begin
			devModeLevel_q <= 1'b0;
			strapState_q <= 1'b0;
		end else begin
			devModeLevel_q <= testSync;
			strapState_q <= strapSync;
		end
	end

	assign swkMode = trxMode[`WGS_TRX_SWK_BIT];

	// a rewrite of the same mode does not re-arm; code 100 never arms
	assign modeChangeArms = trxModeWrite && (trxMode != trxPrev_q) &&
		(trxMode != `WGS_TRX_NO_ACT);

	always @* begin
		active_d = active_q;
		if (swkSystemError || !configValid || !swkMode)
			active_d = 1'b0;
		else if (modeChangeArms)
			active_d = 1'b1;
	end

	// status bits below follow the selective wake engine; pattern and frame
	// hold until the active bit drops, which a system error also causes
	always @(posedge clk) begin
		if (rst)
			active_q <= 1'b0;
		else
			active_q <= active_d;
	end

	// last written mode, so a repeated write is not taken as a change
	always @(posedge clk) begin
		if (rst)
			trxPrev_q <= `WGS_TRX_RESET;
		else if (trxModeWrite)
			trxPrev_q <= trxMode;
	end

	always @(posedge clk) begin
		if (rst)
			syncSeen_q <= 1'b0;
		else if (!active_q)
			syncSeen_q <= 1'b0;
		else if (frameOk)
			syncSeen_q <= 1'b1;
	end

	// a registered view of the bus, gated by the active bit, not sticky
	always @(posedge clk) begin
		if (rst)
			silence_q <= 1'b0;
		else
			silence_q <= active_q && busSilent;
	end

	always @(posedge clk) begin
		if (rst)
			pattern_q <= 1'b0;
		else if (wakePatternEvent)
			pattern_q <= 1'b1;
		else if (!active_q)
			pattern_q <= 1'b0;
	end

	always @(posedge clk) begin
		if (rst)
			frame_q <= 1'b0;
		else if (wakeFrameEvent && active_q)
			frame_q <= 1'b1;
		else if (!active_q)
			frame_q <= 1'b0;
	end

	// timeout is cleared through the bus status bank, not here
	always @(posedge clk) begin
		if (rst)
			timeout_q <= 1'b0;
		else if (silence_q && swkMode)
			timeout_q <= 1'b1;
	end

	// both outputs come straight from flops
	assign busTimeoutFlag = timeout_q;
	assign selectiveWakeActive = active_q;

	// read word decoded combinationally; unmapped addresses read zero
	always @* begin
		readWord_d = `WGS_ZERO8;
		case (regAddr)
		`WGS_ADDR_WAKE_SRC1: begin
			readWord_d[`WGS_BIT_GPIO_WAKE] = gpioWakeFlag;
		end
		`WGS_ADDR_PIN_LVL: begin
			readWord_d[`WGS_BIT_DEV_LVL] = devModeLevel_q;
			readWord_d[`WGS_BIT_CFG_STRAP] = strapState_q;
			readWord_d[`WGS_BIT_GPIO_PIN_LEVEL] = gpioPinLevel_q;
			readWord_d[`WGS_BIT_WAKE_LVL] = wakePinLevel_q;
		end
		`WGS_ADDR_GPIO_OVERCURRENT_FLAG: begin
			readWord_d[`WGS_BIT_GPIO_OVERCURRENT_FLAG] = gpioOvercurrentFlag;
		end
		`WGS_ADDR_GPIO_OPENLOAD_FLAG: begin
			readWord_d[`WGS_BIT_GPIO_OPENLOAD_FLAG] = gpioOpenloadFlag;
		end
		`WGS_ADDR_SWK: begin
			readWord_d[`WGS_BIT_SYNC] = syncSeen_q;
			readWord_d[`WGS_BIT_SILENCE] = silence_q;
			readWord_d[`WGS_BIT_SWK_ACTIVE] = active_q;
			readWord_d[`WGS_BIT_PATTERN] = pattern_q;
			readWord_d[`WGS_BIT_FRAME] = frame_q;
		end
		`WGS_ADDR_SWK_ECNT: begin
			readWord_d[`WGS_ECNT_MSB:0] = errorCount;
		end
		default: begin
			readWord_d = `WGS_ZERO8;
		end
		endcase
	end

	// data output holds between reads, so a late sample never sees it move
	always @(posedge clk) begin
		if (rst)
			regRdata <= `WGS_ZERO8;
		else if (regRead)
			regRdata <= readWord_d;
	end
endmodule // wgs_status_bank
`default_nettype wire

// File: wgs_status_bank_assertions.sv
// Purpose: port checks for the status bank
// Assumes: read data lands one cycle after the read edge
// Notes: bound to the bank at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module wgs_status_bank_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic [6:0] regAddr,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire logic busSilent,
	input wire logic hvMeasureEnable,
	input wire logic swkSystemError,
	input wire logic configValid,
	input wire logic [2:0] trxMode,
	input wire logic trxModeWrite,
	input wire logic busTimeoutFlag,
	input wire logic selectiveWakeActive
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire rdW = regRead && regAddr == 7'h47;
	wire rdL = regRead && regAddr == 7'h48;
	wire rdS = regRead && regAddr == 7'h70;
	wire swkOk = !swkSystemError && configValid && trxMode[2];
	AST_RSV_WAKE: assert property (rdW |=> !(regRdata & 8'hef))
		else $error("reserved wake bits set");
	AST_RSV_LVL: assert property (rdL |=> !(regRdata & 8'h2e))
		else $error("reserved level bits set");
	AST_SWK_BIT: assert property (
		rdS |=> regRdata[2] == $past(selectiveWakeActive))
		else $error("active bit differs from output");
	AST_HV_CLR: assert property (hvMeasureEnable[*3] ##0 rdL
		|=> !(regRdata & 8'h11))
		else $error("level bits not cleared");
	AST_SWK_OFF: assert property (!swkOk |=> !selectiveWakeActive)
		else $error("active without conditions");
	AST_SWK_ON: assert property ($rose(selectiveWakeActive)
		|-> $past(trxModeWrite) && $past(trxMode) != 3'h4)
		else $error("active without mode write");
	AST_TO_SET: assert property (selectiveWakeActive && busSilent
		##1 trxMode[2] |=> busTimeoutFlag)
		else $error("timeout not set");
	AST_TO_HOLD: assert property (busTimeoutFlag |=> busTimeoutFlag)
		else $error("timeout dropped");
	cover property (rdS ##1 regRdata[2]);
	cover property ($rose(busTimeoutFlag));
	cover property (hvMeasureEnable[*3] ##0 rdL);
endmodule // wgs_status_bank_assertions
bind wgs_status_bank wgs_status_bank_assertions chk_i (.*);
`default_nettype wire

// File: wgs_mcu_model.sv
// Purpose: microcontroller side issuing reads and clears
// Assumes: one access per call, driven on the falling edge
// Notes: idle address is scrambled so a stale one is never trusted
`timescale 1ns/1ps
`default_nettype none
module wgs_mcu_model (
	input wire logic clk,
	output logic [6:0] regAddr,
	output logic regRead,
	output logic regClear,
	input wire logic [7:0] regRdata
);
	initial begin
		regAddr = 7'h00;
		regRead = 1'b0;
		regClear = 1'b0;
	end
	task automatic acc(input logic [6:0] a, input logic cl,
		output logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		regClear = cl;
		@(negedge clk);
		d = regRdata;
		regAddr = ~a;
		regRead = 1'b0;
		regClear = 1'b0;
	endtask
endmodule // wgs_mcu_model
`default_nettype wire

// File: testbench.sv
// Purpose: self-checking bench for the status bank
// Assumes: mcu model issues reads and clears
// Notes: pin levels drawn at random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wakePin, gpioPin, testPin, intStrapPin, modeActive, cyclicMode;
	logic sampleStrobe, wakeEnable, gpioEnable, gpioCyclicSense;
	logic hvMeasureEnable, gpioWakeEvent, gpioOvercurrentEvent;
	logic gpioOpenloadEvent, frameOk, busSilent, wakePatternEvent;
	logic wakeFrameEvent, swkSystemError, configValid, trxModeWrite;
	logic [1:0] gpioConfig;
	logic [2:0] trxMode;
	logic [5:0] errorCount;
	logic [6:0] regAddr;
	logic regRead, regClear, busTimeoutFlag, selectiveWakeActive;
	logic [7:0] regRdata, d;
	int n_errors = 0;
	int tests_run = 0;
	logic [6:0] ra [7] = '{7'h47, 7'h48, 7'h54, 7'h55, 7'h70, 7'h71, 7'h50};
	logic [6:0] fa [3] = '{7'h47, 7'h54, 7'h55};
	logic [7:0] fv [3] = '{8'h10, 8'h40, 8'h40};
	logic [1:0] fc [3] = '{2'h1, 2'h2, 2'h3};
	always #5 clk = ~clk;
	wgs_status_bank wgs_status_bank_i (.*);
	wgs_mcu_model wgs_mcu_model_i (.*);
	task automatic chk(input string n, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic rd(input logic [6:0] a, input logic cl);
		wgs_mcu_model_i.acc(a, cl, d);
	endtask
	function automatic logic [7:0] lvl(input logic g, w);
		return {testPin, intStrapPin, 1'b0, g, 3'h0, w};
	endfunction
	initial begin
		logic eW, eG, st;
		{wakePin, gpioPin, testPin, intStrapPin, cyclicMode} = 5'h00;
		{sampleStrobe, gpioCyclicSense, hvMeasureEnable} = 3'h0;
		{gpioWakeEvent, gpioOvercurrentEvent, gpioOpenloadEvent} = 3'h0;
		{frameOk, busSilent, wakePatternEvent, wakeFrameEvent} = 4'h0;
		{swkSystemError, trxModeWrite} = 2'h0;
		{modeActive, wakeEnable, gpioEnable, configValid} = 4'hf;
		gpioConfig = 2'h0;
		trxMode = 3'h0;
		errorCount = 6'h00;
		void'($urandom(32'h5f3a));
		tick(8);
		rst = 1'b0;
		// unmapped 0x50 is in the list and must read zero too
		foreach (ra[k]) begin
			rd(ra[k], 1'b0);
			chk("reset value", d, 8'h00);
		end
		// wake and open-load events in low-side use must be dropped
		gpioConfig = 2'h2;
		{gpioOpenloadEvent, gpioOvercurrentEvent, gpioWakeEvent} = 3'h5;
		tick(1);
		{gpioOpenloadEvent, gpioOvercurrentEvent, gpioWakeEvent} = 3'h0;
		gpioConfig = 2'h0;
		foreach (fa[k]) begin
			rd(fa[k], 1'b0);
			chk("flag refused", d, 8'h00);
		end
		for (int i = 0; i < 3; i++) begin
			gpioConfig = fc[i];
			{gpioOpenloadEvent, gpioOvercurrentEvent, gpioWakeEvent} = 3'h1 << i;
			tick(1);
			{gpioOpenloadEvent, gpioOvercurrentEvent, gpioWakeEvent} = 3'h0;
			gpioConfig = 2'h0;
			rd(fa[i], 1'b0);
			chk("flag set", d, fv[i]);
			rd(fa[i], 1'b1);
			chk("flag held", d, fv[i]);
			rd(fa[i], 1'b0);
			chk("flag cleared", d, 8'h00);
		end
		eW = 1'b0;
		eG = 1'b0;
		for (int i = 0; i < 40; i++) begin
			{wakePin, gpioPin, testPin, intStrapPin} = 4'($urandom);
			{modeActive, cyclicMode, wakeEnable, gpioEnable} = 4'($urandom);
			{gpioCyclicSense, hvMeasureEnable, st} = 3'($urandom);
			gpioConfig = 2'($urandom);
			errorCount = 6'($urandom);
			tick(4);
			sampleStrobe = st;
			tick(1);
			sampleStrobe = 1'b0;
			tick(2);
			if (hvMeasureEnable) begin
				eW = 1'b0;
				eG = 1'b0;
			end else if (modeActive && (!cyclicMode || st)) begin
				if (wakeEnable)
					eW = wakePin;
				if (gpioEnable && gpioConfig != 2'h0 && !gpioCyclicSense)
					eG = gpioPin;
			end
			rd(7'h48, 1'b0);
			chk("levels", d, lvl(eG, eW));
			rd(7'h71, 1'b0);
			chk("error count", d, {2'h0, errorCount});
		end
		{hvMeasureEnable, modeActive} = 2'h1;
		for (int m = 0; m < 2; m++) begin
			trxMode = m ? 3'h6 : 3'h4;
			trxModeWrite = 1'b1;
			tick(1);
			trxModeWrite = 1'b0;
			rd(7'h70, 1'b0);
			chk("mode write", d, m ? 8'h04 : 8'h00);
			chk("active out", {7'h00, selectiveWakeActive}, 8'(m));
		end
		frameOk = 1'b1;
		tick(1);
		frameOk = 1'b0;
		rd(7'h70, 1'b0);
		chk("sync", d, 8'h44);
		{wakePatternEvent, wakeFrameEvent} = 2'h3;
		tick(1);
		{wakePatternEvent, wakeFrameEvent} = 2'h0;
		rd(7'h70, 1'b0);
		chk("pattern frame", d, 8'h47);
		busSilent = 1'b1;
		tick(3);
		rd(7'h70, 1'b0);
		chk("silence", d, 8'h4f);
		busSilent = 1'b0;
		tick(2);
		rd(7'h70, 1'b0);
		chk("silence gone", d, 8'h47);
		swkSystemError = 1'b1;
		tick(2);
		rd(7'h70, 1'b0);
		chk("system error", d, 8'h00);
		chk("active drop", {7'h00, selectiveWakeActive}, 8'h00);
		chk("timeout", {7'h00, busTimeoutFlag}, 8'h01);
		results();
	end
	initial begin
		#1000000;
		n_errors++;
		results();
	end
endmodule // testbench
`default_nettype wire
